// ---- src/fssr_top.sv ----
// Purpose: erase/program sequencer with suspend and resume policy
// Assumes: classic Wishbone master, one request at a time
// Notes:   host misuse is refused and recorded in sticky flags
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ps
module fssr_top import fssr_pkg::*; #(
  parameter int unsigned ERASE_CYC      = 4000,
  parameter int unsigned PROG_CYC       = 2000,
  parameter int unsigned SUSP_CYC       = FSSR_SUSP_MAX_CYC,
  parameter int unsigned RESUME_GAP_CYC = FSSR_RESUME_GAP_CYC,
  parameter int unsigned ADDR_W         = 24,
  parameter int unsigned SECT_W         = 12,
  parameter int unsigned PAGE_W         = 9
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // status
  output logic             busy_o,
  output logic             suspended_o
);

  logic              ack_q;
  logic [31:0]       rdat_q;
  logic              acc;
  logic              wr;
  logic [7:0]        word_adr;
  logic              cmd_wr;
  fssr_cmd_t         cmd;
  logic [31:0]       addr_q;
  fssr_state_t       state_q;
  fssr_state_t       state_d;
  logic              op_erase_q;
  logic [ADDR_W-1:0] op_addr_q;
  logic [15:0]       rem_q;
  logic [3:0]        flags_q;
  logic [3:0]        flag_set;
  logic [3:0]        flag_clr;
  logic              start;
  logic              lat_load;
  logic [15:0]       lat_val;
  logic              lat_exp;
  logic              gap_load;
  logic              gap_busy;
  logic              guard_ref;
  logic              refuse;
  logic              early;
  logic              notrdy;
  logic              done_ev;

  // bus decode: a write takes effect at the edge where ack is high
  assign acc      = wb_cyc_i & wb_stb_i & ack_q;
  assign wr       = acc & wb_we_i;
  assign word_adr = {wb_adr_i[7:2], 2'h0};
  assign cmd_wr   = wr && (word_adr == FSSR_REG_CTRL) && wb_sel_i[0];
  assign cmd      = fssr_cmd_t'(wb_dat_i[2:0]);

  // one wait state answer, ack dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end

  // read data captured with ack; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0;
    end else if (wb_cyc_i & wb_stb_i & ~ack_q) begin
      case (word_adr)
        FSSR_REG_ADDR:   rdat_q <= addr_q;
        FSSR_REG_STATUS: rdat_q <= {26'h0, gap_busy, op_erase_q, rem_q != 16'h0, state_q};
        FSSR_REG_FLAGS:  rdat_q <= {28'h0, flags_q};
        FSSR_REG_PARAM:  rdat_q <= FSSR_PARAM_WORD;
        default:         rdat_q <= 32'h0;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // address register, one generate lane per byte enable
  for (genvar b = 0; b < 4; b++) begin : g_addr_lane
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        addr_q[8*b +: 8] <= FSSR_ADDR_RST[8*b +: 8];
      end else if (wr && (word_adr == FSSR_REG_ADDR) && wb_sel_i[b]) begin
        addr_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
      end
    end
  end

  // suspend latency and side-program duration share one timer
  fssr_timer #(.W(16)) u_lat (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .load_i   (lat_load),
    .value_i  (lat_val),
    .active_o (),
    .expire_o (lat_exp)
  );

  // resume-to-suspend spacing
  fssr_timer #(.W(16)) u_gap (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .load_i   (gap_load),
    .value_i  (16'(RESUME_GAP_CYC)),
    .active_o (gap_busy),
    .expire_o ()
  );

  fssr_guard #(.ADDR_W(ADDR_W), .SECT_W(SECT_W), .PAGE_W(PAGE_W)) u_guard (
    .cmd_valid_i  (cmd_wr),
    .cmd_i        (cmd),
    .addr_i       (addr_q[ADDR_W-1:0]),
    .erase_held_i (op_erase_q),
    .held_addr_i  (op_addr_q),
    .refuse_o     (guard_ref)
  );

  // sequencer next state and event decode
  always_comb begin
    state_d  = state_q;
    start    = 1'b0;
    lat_load = 1'b0;
    lat_val  = 16'(SUSP_CYC);
    gap_load = 1'b0;
    refuse   = 1'b0;
    early    = 1'b0;
    notrdy   = 1'b0;
    done_ev  = 1'b0;
    case (state_q)
      FSSR_ST_IDLE: begin
        if (cmd_wr && (cmd == FSSR_CMD_ERASE || cmd == FSSR_CMD_PROGRAM)) begin
          state_d = FSSR_ST_RUN;
          start   = 1'b1;
        end else if (cmd_wr && cmd != FSSR_CMD_READ) begin
          refuse = 1'b1;
        end
      end
      FSSR_ST_RUN: begin
        // completion wins over a suspend in the same cycle
        if (rem_q == 16'h1) begin
          state_d = FSSR_ST_IDLE;
          done_ev = 1'b1;
          refuse  = cmd_wr;
        end else if (cmd_wr && cmd == FSSR_CMD_SUSPEND) begin
          if (gap_busy) begin
            early = 1'b1;
          end else begin
            state_d  = FSSR_ST_SUSPENDING;
            lat_load = 1'b1;
          end
        end else if (cmd_wr) begin
          refuse = 1'b1;
        end
      end
      FSSR_ST_SUSPENDING: begin
        if (lat_exp) begin
          state_d = FSSR_ST_SUSPENDED;
        end
        notrdy = cmd_wr;
      end
      FSSR_ST_SUSPENDED: begin
        if (cmd_wr && cmd == FSSR_CMD_RESUME) begin
          state_d  = FSSR_ST_RUN;
          gap_load = 1'b1;
        end else if (cmd_wr && guard_ref) begin
          refuse = 1'b1;
        end else if (cmd_wr && cmd == FSSR_CMD_PROGRAM) begin
          state_d  = FSSR_ST_SIDE;
          lat_load = 1'b1;
          lat_val  = 16'(PROG_CYC);
        end else if (cmd_wr && cmd != FSSR_CMD_READ) begin
          refuse = 1'b1;
        end
      end
      FSSR_ST_SIDE: begin
        if (lat_exp) begin
          state_d = FSSR_ST_SUSPENDED;
        end
        refuse = cmd_wr;
      end
      default: begin
        state_d = FSSR_ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= FSSR_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // operation kind, target and remaining work; frozen while suspended
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_erase_q <= 1'b0;
      op_addr_q  <= '0;
      rem_q      <= 16'h0;
    end else if (start) begin
      op_erase_q <= (cmd == FSSR_CMD_ERASE);
      op_addr_q  <= addr_q[ADDR_W-1:0];
      rem_q      <= (cmd == FSSR_CMD_ERASE) ? 16'(ERASE_CYC) : 16'(PROG_CYC);
    end else if (state_q == FSSR_ST_RUN && rem_q != 16'h0) begin
      rem_q <= rem_q - 16'h1;
    end
  end

  // sticky flags, write one to clear; a new event beats the clear
  assign flag_set = {notrdy, early, refuse, done_ev};
  assign flag_clr = (wr && word_adr == FSSR_REG_FLAGS && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= FSSR_FLAGS_RST;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  assign busy_o      = (state_q != FSSR_ST_IDLE);
  assign suspended_o = (state_q == FSSR_ST_SUSPENDED);

  // checks; the latency bound is the promised 40 us, not the SUSP_CYC in use
  localparam logic [15:0] LAT_BOUND = 16'(FSSR_SUSP_MAX_CYC);

  // cycles spent suspending, saturating; a counter keeps the bound out of a
  // long delay range that the tools would have to unroll
  logic [15:0] susp_age_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      susp_age_q <= 16'h0;
    end else if (state_q != FSSR_ST_SUSPENDING) begin
      susp_age_q <= 16'h0;
    end else if (susp_age_q != 16'hffff) begin
      susp_age_q <= susp_age_q + 16'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // advertised parameter dword
  param_msb_a: assert property (
    wb_ack_o && !wb_we_i && word_adr == FSSR_REG_PARAM |-> wb_dat_o[31] == 1'b0)
    else $error("param msb not zero");
  param_unit_a: assert property (
    wb_ack_o && !wb_we_i && word_adr == FSSR_REG_PARAM
    |-> wb_dat_o[30:29] == 2'h2 && wb_dat_o[19:18] == 2'h2)
    else $error("bad unit");
  param_word_a: assert property (
    wb_ack_o && !wb_we_i && word_adr == FSSR_REG_PARAM |-> wb_dat_o == 32'h441883ec)
    else $error("param dword wrong");

  // suspend latency, measured in whole cycles spent suspending
  erase_lat_a: assert property (
    state_q == FSSR_ST_SUSPENDING && op_erase_q |-> susp_age_q < LAT_BOUND)
    else $error("erase suspend late");
  prog_lat_a: assert property (
    state_q == FSSR_ST_SUSPENDING && !op_erase_q |-> susp_age_q < LAT_BOUND)
    else $error("prog suspend late");

  // host misuse must come back as a flag and leave the state alone
  early_susp_a: assert property (
    state_q == FSSR_ST_RUN && cmd_wr && cmd == FSSR_CMD_SUSPEND && gap_busy && rem_q != 16'h1
    |=> state_q == FSSR_ST_RUN && flags_q[FSSR_FLG_EARLY])
    else $error("early suspend taken");
  no_nest_a: assert property (
    state_q == FSSR_ST_SUSPENDED && cmd_wr && cmd == FSSR_CMD_ERASE
    |=> state_q == FSSR_ST_SUSPENDED && flags_q[FSSR_FLG_REFUSE])
    else $error("nested erase taken");
  sect_prog_a: assert property (
    state_q == FSSR_ST_SUSPENDED && op_erase_q && cmd_wr && cmd == FSSR_CMD_PROGRAM
    && addr_q[ADDR_W-1:SECT_W] == op_addr_q[ADDR_W-1:SECT_W]
    |=> state_q != FSSR_ST_SIDE) else $error("program into held sector");
  read_sect_a: assert property (
    state_q == FSSR_ST_SUSPENDED && op_erase_q && cmd_wr && cmd == FSSR_CMD_READ
    && addr_q[ADDR_W-1:SECT_W] == op_addr_q[ADDR_W-1:SECT_W]
    |=> flags_q[FSSR_FLG_REFUSE]) else $error("read in held sector passed");
  prog_nest_a: assert property (
    state_q == FSSR_ST_SUSPENDED && !op_erase_q && cmd_wr && cmd == FSSR_CMD_PROGRAM
    |=> state_q == FSSR_ST_SUSPENDED && flags_q[FSSR_FLG_REFUSE])
    else $error("nested program taken");
  read_page_a: assert property (
    state_q == FSSR_ST_SUSPENDED && !op_erase_q && cmd_wr && cmd == FSSR_CMD_READ
    && addr_q[ADDR_W-1:PAGE_W] == op_addr_q[ADDR_W-1:PAGE_W]
    |=> flags_q[FSSR_FLG_REFUSE]) else $error("read in held page passed");
  busy_susp_a: assert property (
    state_q == FSSR_ST_SUSPENDING && cmd_wr |=> flags_q[FSSR_FLG_NOTRDY])
    else $error("command while suspending not flagged");
  resume_gap_a: assert property (
    $fell(state_q == FSSR_ST_SUSPENDED) && state_q == FSSR_ST_RUN |-> gap_busy [*8])
    else $error("resume guard not armed");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");

  erase_susp_c: cover property (state_q == FSSR_ST_SUSPENDED && op_erase_q);
  prog_susp_c: cover property (state_q == FSSR_ST_SUSPENDED && !op_erase_q);
  side_prog_c: cover property (state_q == FSSR_ST_SIDE ##1 state_q == FSSR_ST_SUSPENDED);
  resume_c: cover property (state_q == FSSR_ST_SUSPENDED ##1 state_q == FSSR_ST_RUN);
  notrdy_c: cover property (state_q == FSSR_ST_SUSPENDING && cmd_wr);

endmodule

// ---- src/fssr_pkg.sv ----
// Purpose: shared constants and types of the suspend/resume sequencer
// Assumes: 40 MHz clock, classic Wishbone register access
// Notes:   the parameter dword is assembled from its fields here
// How it works
// - bit 31 zero: suspend/resume supported
// - latency unit codes; 8 us code 10
// - erase reaches suspended within 40 us
// - program reaches suspended within 40 us
// - dword reads EC 83 18 44 at 2C..2F
package fssr_pkg;

  // clock and times
  localparam int unsigned FSSR_CLK_PERIOD_NS   = 25;
  localparam int unsigned FSSR_SUSP_MAX_NS     = 40000;
  localparam int unsigned FSSR_RESUME_GAP_NS   = 128000;
  // longest time rounds down, least time rounds up
  localparam int unsigned FSSR_SUSP_MAX_CYC    = FSSR_SUSP_MAX_NS / FSSR_CLK_PERIOD_NS;
  localparam int unsigned FSSR_RESUME_GAP_CYC  =
    (FSSR_RESUME_GAP_NS + FSSR_CLK_PERIOD_NS - 1) / FSSR_CLK_PERIOD_NS;

  // latency unit encodings
  localparam logic [1:0] FSSR_UNIT_128NS = 2'h0;
  localparam logic [1:0] FSSR_UNIT_1US   = 2'h1;
  localparam logic [1:0] FSSR_UNIT_8US   = 2'h2;
  localparam logic [1:0] FSSR_UNIT_64US  = 2'h3;

  // parameter dword fields
  localparam logic       FSSR_F_UNSUPPORTED = 1'b0;
  localparam logic [4:0] FSSR_F_ERS_LAT_CNT = 5'h04;
  localparam logic [3:0] FSSR_F_ERS_GAP_CNT = 4'h1;
  localparam logic [4:0] FSSR_F_PRG_LAT_CNT = 5'h04;
  localparam logic [3:0] FSSR_F_PRG_GAP_CNT = 4'h1;
  localparam logic       FSSR_F_RFU         = 1'b1;
  localparam logic [3:0] FSSR_F_ERS_PROHIB  = 4'he;
  localparam logic [3:0] FSSR_F_PRG_PROHIB  = 4'hc;
  localparam logic [31:0] FSSR_PARAM_WORD = {FSSR_F_UNSUPPORTED, FSSR_UNIT_8US,
    FSSR_F_ERS_LAT_CNT, FSSR_F_ERS_GAP_CNT, FSSR_UNIT_8US, FSSR_F_PRG_LAT_CNT,
    FSSR_F_PRG_GAP_CNT, FSSR_F_RFU, FSSR_F_ERS_PROHIB, FSSR_F_PRG_PROHIB};

  // register byte offsets
  localparam logic [7:0] FSSR_REG_CTRL   = 8'h00;
  localparam logic [7:0] FSSR_REG_ADDR   = 8'h04;
  localparam logic [7:0] FSSR_REG_STATUS = 8'h08;
  localparam logic [7:0] FSSR_REG_FLAGS  = 8'h0c;
  localparam logic [7:0] FSSR_REG_PARAM  = 8'h2c;

  // flag bit positions and reset values
  localparam int unsigned FSSR_FLG_DONE   = 0;
  localparam int unsigned FSSR_FLG_REFUSE = 1;
  localparam int unsigned FSSR_FLG_EARLY  = 2;
  localparam int unsigned FSSR_FLG_NOTRDY = 3;
  localparam logic [3:0]  FSSR_FLAGS_RST  = 4'h0;
  localparam logic [31:0] FSSR_ADDR_RST   = 32'h0;

  typedef enum logic [2:0] {
    FSSR_CMD_NONE    = 3'h0,
    FSSR_CMD_ERASE   = 3'h1,
    FSSR_CMD_PROGRAM = 3'h2,
    FSSR_CMD_SUSPEND = 3'h3,
    FSSR_CMD_RESUME  = 3'h4,
    FSSR_CMD_READ    = 3'h5
  } fssr_cmd_t;

  // gray along idle -> run -> suspending -> suspended -> side program
  typedef enum logic [2:0] {
    FSSR_ST_IDLE       = 3'h0,
    FSSR_ST_RUN        = 3'h1,
    FSSR_ST_SUSPENDING = 3'h3,
    FSSR_ST_SUSPENDED  = 3'h2,
    FSSR_ST_SIDE       = 3'h6
  } fssr_state_t;

endpackage

// ---- src/fssr_timer.sv ----
// Purpose: loadable down counter for latency and guard intervals
// Assumes: value_i at least one when loaded
// Notes:   expire_o marks the last counted cycle
`timescale 1ns/1ps
module fssr_timer #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // control
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  // state
  output logic              active_o,
  output logic              expire_o
);

  logic [W-1:0] cnt_q;

  // count down to zero and stop there
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= value_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign active_o = (cnt_q != '0);
  assign expire_o = (cnt_q == W'(1));

endmodule

// ---- src/fssr_guard.sv ----
// Purpose: checks a command against the suspended operation's region
// Assumes: only consulted while an operation is suspended
// Notes:   purely combinational
`timescale 1ns/1ps
module fssr_guard import fssr_pkg::*; #(
  parameter int unsigned ADDR_W = 24,
  parameter int unsigned SECT_W = 12,
  parameter int unsigned PAGE_W = 9
) (
  // request
  input  wire logic              cmd_valid_i,
  input  wire logic [2:0]        cmd_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  // suspended operation
  input  wire logic              erase_held_i,
  input  wire logic [ADDR_W-1:0] held_addr_i,
  // verdict
  output logic                   refuse_o
);

  logic same_sect;
  logic same_page;

  assign same_sect = (addr_i[ADDR_W-1:SECT_W] == held_addr_i[ADDR_W-1:SECT_W]);
  assign same_page = (addr_i[ADDR_W-1:PAGE_W] == held_addr_i[ADDR_W-1:PAGE_W]);

  // region checks per command
  always_comb begin
    refuse_o = 1'b0;
    if (cmd_valid_i) begin
      case (cmd_i)
        FSSR_CMD_ERASE:   refuse_o = 1'b1;
        FSSR_CMD_PROGRAM: refuse_o = erase_held_i ? same_sect : 1'b1;
        FSSR_CMD_READ:    refuse_o = erase_held_i ? same_sect : same_page;
        default:          refuse_o = 1'b0;
      endcase
    end
  end

endmodule

// ---- test/fssr_host.sv ----
// Purpose: host side model, a classic Wishbone master for the sequencer
// Assumes: the slave acks each request within a few cycles
// Notes:   one request in flight; cyc and stb drop for a cycle after each ack
`timescale 1ns/1ps
module fssr_host (
  // clock
  input  wire logic        clk_i,
  // wishbone master
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i
);
  // bus idle until the first request
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end

  // one classic cycle; hung reports an ack that never came
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic hung);
    int n;
    hung = 1'b1;
    rd   = 32'h0;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'hf;
    wb_dat_o <= wd;
    // request held until ack is seen at a rising edge
    for (n = 0; n < 16; n++) begin
      @(posedge clk_i);
      if (wb_ack_i === 1'b1) begin
        rd   = wb_dat_i;
        hung = 1'b0;
        break;
      end
    end
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_dat_o <= ~wd; // released data must not look like the last word
  endtask
endmodule

// ---- test/tb_flash_suspend_resume_policy.sv ----
// Purpose: self-checking bench of the suspend/resume sequencer
// Assumes: shortened run, suspend latency and resume guard counts
// Notes:   misuse is issued on purpose and must come back as refusal flags
`timescale 1ns/1ps
module tb_flash_suspend_resume_policy import fssr_pkg::*;;
  localparam int unsigned SUSP = 8;
  localparam int unsigned GAP  = 16;
  localparam int unsigned PROG = 20;

  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        busy_o;
  logic        suspended_o;
  int          miscompares;
  int          total_checks;

  // 40 MHz clock
  initial clk_i = 1'b0;
  always #12.5 clk_i = ~clk_i;

  // the erase must outlast both suspends and the guard wait between them
  fssr_top #(.ERASE_CYC(100), .PROG_CYC(PROG), .SUSP_CYC(SUSP), .RESUME_GAP_CYC(GAP))
  fssr_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o), .suspended_o(suspended_o));

  fssr_host fssr_host_inst (.clk_i(clk_i), .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i),
    .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i),
    .wb_dat_i(wb_dat_o), .wb_ack_i(wb_ack_o));

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  // a missing ack ends the run at once
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    logic hung;
    fssr_host_inst.xfer(we, a, d, q, hung);
    if (hung) begin
      $display("Error wb_ack_o expected 1 seen 0");
      miscompares++;
      test_done();
    end
  endtask

  task automatic cmd(input fssr_cmd_t c, input logic [23:0] a);
    logic [31:0] q;
    bus(1'b1, FSSR_REG_ADDR, {8'h00, a}, q);
    bus(1'b1, FSSR_REG_CTRL, {29'h0, c}, q);
  endtask

  // read the sticky flags, then clear them by writing ones
  task automatic flags_chk(input logic [3:0] exp);
    logic [31:0] q;
    bus(1'b0, FSSR_REG_FLAGS, 32'h0, q);
    chk("flags", {28'h0, exp}, {28'h0, q[3:0]});
    bus(1'b1, FSSR_REG_FLAGS, 32'hf, q);
  endtask

  // suspension must arrive within lim edges, one edge of sampling slack included
  task automatic wait_susp(input int lim);
    int n;
    for (n = 0; n < 64; n++) begin
      if (suspended_o === 1'b1) break;
      @(posedge clk_i);
    end
    chk("suspend in time", 32'h1, {31'h0, n <= lim});
    if (n >= 64) test_done();
  endtask

  task automatic wait_idle();
    int n;
    for (n = 0; n < 300; n++) begin
      if (busy_o === 1'b0) break;
      @(posedge clk_i);
    end
    chk("returned idle", 32'h1, {31'h0, n < 300});
    if (n >= 300) test_done();
  endtask

  // parameter dword, its fields, an unmapped place and idle refusal
  task automatic t_param();
    logic [31:0] q;
    bus(1'b0, FSSR_REG_PARAM, 32'h0, q);
    chk("param word", 32'h441883ec, q);
    chk("supported bit", 32'h0, {31'h0, q[31]});
    chk("erase unit", 32'h2, {30'h0, q[30:29]});
    chk("erase latency", 32'h4, {27'h0, q[28:24]});
    chk("erase gap", 32'h1, {28'h0, q[23:20]});
    chk("program unit", 32'h2, {30'h0, q[19:18]});
    chk("program latency", 32'h4, {27'h0, q[17:13]});
    chk("program gap", 32'h1, {28'h0, q[12:9]});
    chk("erase prohibit", 32'he, {28'h0, q[7:4]});
    chk("program prohibit", 32'hc, {28'h0, q[3:0]});
    bus(1'b1, FSSR_REG_PARAM, 32'h0, q);
    bus(1'b0, FSSR_REG_PARAM, 32'h0, q);
    chk("param after write", 32'h441883ec, q);
    bus(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", 32'h0, q);
    bus(1'b1, FSSR_REG_ADDR, 32'h89ab4c2d, q);
    bus(1'b0, FSSR_REG_ADDR, 32'h0, q);
    chk("addr readback", 32'h89ab4c2d, q);
    flags_chk(4'h0);
    cmd(FSSR_CMD_SUSPEND, 24'h000000);
    flags_chk(4'h2);
    $display("test param done");
  endtask

  // erase suspended: forbidden work refused, early suspend refused, late one taken
  task automatic t_erase();
    logic [31:0] q;
    cmd(FSSR_CMD_ERASE, 24'h001010);
    cmd(FSSR_CMD_SUSPEND, 24'h001010);
    wait_susp(SUSP + 1);
    cmd(FSSR_CMD_ERASE, 24'h005000);
    flags_chk(4'h2);
    cmd(FSSR_CMD_PROGRAM, 24'h001800);
    flags_chk(4'h2);
    cmd(FSSR_CMD_READ, 24'h001020);
    flags_chk(4'h2);
    cmd(FSSR_CMD_READ, 24'h002000);
    flags_chk(4'h0);
    // program in another sector runs beside the held erase, then suspends again
    cmd(FSSR_CMD_PROGRAM, 24'h003000);
    bus(1'b0, FSSR_REG_STATUS, 32'h0, q);
    chk("status side program", {27'h0, 2'h3, 3'(FSSR_ST_SIDE)}, q);
    cmd(FSSR_CMD_READ, 24'h002000);
    flags_chk(4'h2);
    wait_susp(PROG + 1);
    chk("still suspended", 32'h1, {31'h0, suspended_o});
    cmd(FSSR_CMD_RESUME, 24'h001010);
    cmd(FSSR_CMD_SUSPEND, 24'h001010);
    flags_chk(4'h4);
    repeat (GAP + 2) @(posedge clk_i);
    cmd(FSSR_CMD_SUSPEND, 24'h001010);
    cmd(FSSR_CMD_READ, 24'h002000);
    flags_chk(4'h8);
    wait_susp(SUSP + 1);
    cmd(FSSR_CMD_RESUME, 24'h001010);
    wait_idle();
    flags_chk(4'h1);
    $display("test erase done");
  endtask

  // program suspended: no nesting, no read in the held page
  task automatic t_prog();
    cmd(FSSR_CMD_PROGRAM, 24'h000200);
    cmd(FSSR_CMD_SUSPEND, 24'h000200);
    wait_susp(SUSP + 1);
    cmd(FSSR_CMD_ERASE, 24'h008000);
    flags_chk(4'h2);
    cmd(FSSR_CMD_PROGRAM, 24'h004000);
    flags_chk(4'h2);
    cmd(FSSR_CMD_READ, 24'h0003f0);
    flags_chk(4'h2);
    cmd(FSSR_CMD_READ, 24'h000400);
    flags_chk(4'h0);
    cmd(FSSR_CMD_RESUME, 24'h000200);
    cmd(FSSR_CMD_SUSPEND, 24'h000200);
    flags_chk(4'h4);
    wait_idle();
    flags_chk(4'h1);
    $display("test program done");
  endtask

  // reset for 16 cycles, then the scenarios
  initial begin
    miscompares  = 0;
    total_checks = 0;
    rst_i        = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_param();
    t_erase();
    t_prog();
    test_done();
  end
endmodule
